// File: design/register_access_front_end.v
// Purpose: register front end behind the serial control target logic
// Assumes: the bus target delivers whole byte transactions as strobes
// Notes:   two-stage pipe: take request, then act and answer
`timescale 1ns/10ps
`include "reg_front_end_consts.vh"

module register_access_front_end #(
	parameter [6:0] MAIN_ID  = 7'h30,
	parameter [7:0] IDENT_0  = 8'h61, // arbitrary value
	parameter [7:0] IDENT_1  = 8'h62, // arbitrary value
	parameter [7:0] IDENT_2  = 8'h63, // arbitrary value
	parameter [7:0] IDENT_3  = 8'h64, // arbitrary value
	parameter [7:0] IDENT_4  = 8'h65, // arbitrary value
	parameter [7:0] IDENT_5  = 8'h66  // arbitrary value
) (
	input  wire       REF_CLK,
	input  wire       RST_N,
	input  wire [6:0] ACC_ID,
	input  wire [7:0] ACC_OFFSET,
	input  wire [7:0] ACC_WDATA,
	input  wire       ACC_WR,
	input  wire       ACC_RD,
	output wire       ACC_HIT,
	output reg  [7:0] ACC_RDATA,
	output reg        ACC_RVALID,
	input  wire [3:0] PORT_LOCK,
	input  wire [3:0] PORT_VALID,
	output wire       PORT_WR,
	output wire       PORT_RD,
	output reg  [1:0] PORT_NUM,
	output reg  [7:0] PORT_OFFSET,
	output reg  [7:0] PORT_WDATA,
	input  wire [7:0] PORT_RDATA,
	output wire       IND_WR,
	output wire       IND_RD,
	output wire [3:0] IND_BLOCK,
	output reg  [7:0] IND_ADDR,
	input  wire [7:0] IND_RDATA
);

	// ************************************************************
	// state
	// ************************************************************
	reg  [7:0]  indirect_block_control;
	reg  [1:0]  page_sel;
	reg  [6:0]  port_id [0:3];
	reg  [3:0]  lock_change_irq_enable;
	reg  [3:0]  lock_change_irq_flag;
	reg  [3:0]  port_valid_change_flag;
	reg  [3:0]  lock_changed_status;
	reg  [3:0]  lock_prev;
	reg  [3:0]  valid_prev;
	reg         s_wr;
	reg         s_rd;
	reg         s_main;
	wire        id_main;
	wire [3:0]  id_port;
	wire        direct_hit;
	wire [1:0]  direct_num;
	wire        s_local;
	wire        s_ind_data;
	wire [3:0]  sts_read;
	wire [3:0]  lock_evt;
	wire [3:0]  valid_evt;
	reg  [7:0]  next_rdata;
	wire [1:0]  id_sel;

	// one-hot to index, lowest port first when identifiers collide
	function [1:0] first_port;
		input [3:0] hits;
		begin
			if (hits[0]) begin
				first_port = 2'h0;
			end else if (hits[1]) begin
				first_port = 2'h1;
			end else if (hits[2]) begin
				first_port = 2'h2;
			end else begin
				first_port = 2'h3;
			end
		end
	endfunction

	// is this offset one of the per-port registers kept here
	function is_port_local;
		input [7:0] ofs;
		begin
			is_port_local = (ofs == `OFS_STS_ONE) ||
				(ofs == `OFS_IRQ_EN) || (ofs == `OFS_IRQ_STS);
		end
	endfunction

	// ************************************************************
	// identifier decode
	// ************************************************************
	assign id_main = (ACC_ID == MAIN_ID);
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_dec
			// zero identifier keeps the window shut
			assign id_port[g] = (port_id[g] != `RST_ID) &&
				(port_id[g] == ACC_ID) && !id_main;
		end
	endgenerate
	assign direct_hit = |id_port;
	assign direct_num = first_port(id_port);
	assign ACC_HIT    = id_main || direct_hit;

	// ************************************************************
	// request stage: capture target, offset and data
	// ************************************************************
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_wr        <= 1'b0;
			s_rd        <= 1'b0;
			s_main      <= 1'b0;
			PORT_NUM    <= `RST_PAGE;
			PORT_OFFSET <= `RST_BYTE;
			PORT_WDATA  <= `RST_BYTE;
		end else begin
			s_wr        <= ACC_WR && ACC_HIT;
			s_rd        <= ACC_RD && ACC_HIT && !ACC_WR;
			s_main      <= id_main;
			// main space reaches the port chosen by the page register
			PORT_NUM    <= id_main ? page_sel : direct_num;
			PORT_OFFSET <= ACC_OFFSET;
			PORT_WDATA  <= ACC_WDATA;
		end
	end

	assign s_local    = is_port_local(PORT_OFFSET);
	assign id_sel     = PORT_OFFSET[`ID_SEL_HI:`ID_SEL_LO];
	assign s_ind_data = s_main && (PORT_OFFSET == `OFS_IND_DATA);
	// direct windows forward all non-local offsets of that port only
	assign PORT_WR    = s_wr && !s_main && !s_local;
	assign PORT_RD    = s_rd && !s_main && !s_local;
	assign IND_WR     = s_wr && s_ind_data;
	assign IND_RD     = s_rd && s_ind_data;
	assign IND_BLOCK  =
		indirect_block_control[`CTL_BLK_HI:`CTL_BLK_LO];

	// ************************************************************
	// main space registers and indirect offset
	// ************************************************************
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			indirect_block_control <= `RST_BYTE;
			IND_ADDR               <= `RST_BYTE;
			page_sel               <= `RST_PAGE;
			port_id[0]             <= `RST_ID;
			port_id[1]             <= `RST_ID;
			port_id[2]             <= `RST_ID;
			port_id[3]             <= `RST_ID;
		end else begin
			if (s_wr && s_main) begin
				case (PORT_OFFSET)
				`OFS_IND_CTL: begin
					indirect_block_control <= PORT_WDATA;
				end
				`OFS_IND_ADDR: begin
					IND_ADDR <= PORT_WDATA;
				end
				`OFS_PAGE_SEL: begin
					page_sel <= PORT_WDATA[`PAGE_HI:`PAGE_LO];
				end
				default: begin
				end
				endcase
				if (PORT_OFFSET >= `OFS_PORT_ID_LO &&
					PORT_OFFSET <= `OFS_PORT_ID_HI) begin
					port_id[id_sel] <=
						PORT_WDATA[`ID_HI:`ID_LO];
				end
			end
			// wraps at the top of the offset space; no step when off
			if ((s_wr || s_rd) && s_ind_data &&
				indirect_block_control[`CTL_AUTO_INC]) begin
				IND_ADDR <= IND_ADDR + `ONE_BYTE;
			end
		end
	end

	// ************************************************************
	// per-port lock and valid events
	// ************************************************************
	// first cycle after reset compares against low, so a high input
	// sitting on its pin at release reports one change
	assign lock_evt  = PORT_LOCK ^ lock_prev;
	assign valid_evt = PORT_VALID ^ valid_prev;

	generate
		for (g = 0; g < 4; g = g + 1) begin : g_port
			assign sts_read[g] = s_rd && s_local &&
				(PORT_OFFSET == `OFS_STS_ONE) && (PORT_NUM == g);

			// set wins over the read clear so no change is lost
			always @(posedge REF_CLK or negedge RST_N) begin
				if (!RST_N) begin
					lock_prev[g]              <= 1'b0;
					valid_prev[g]             <= 1'b0;
					lock_change_irq_enable[g] <= 1'b0;
					lock_change_irq_flag[g]   <= 1'b0;
					port_valid_change_flag[g] <= 1'b0;
					lock_changed_status[g]    <= 1'b0;
				end else begin
					lock_prev[g]  <= PORT_LOCK[g];
					valid_prev[g] <= PORT_VALID[g];
					if (s_wr && s_local && PORT_NUM == g &&
						PORT_OFFSET == `OFS_IRQ_EN) begin
						lock_change_irq_enable[g] <=
							PORT_WDATA[`IER_LOCK];
					end
					if (valid_evt[g]) begin
						port_valid_change_flag[g] <= 1'b1;
					end else if (sts_read[g]) begin
						port_valid_change_flag[g] <= 1'b0;
					end
					if (lock_evt[g] && lock_change_irq_enable[g]) begin
						lock_change_irq_flag[g] <= 1'b1;
					end else if (sts_read[g]) begin
						lock_change_irq_flag[g] <= 1'b0;
					end
					if (lock_evt[g]) begin
						lock_changed_status[g] <= 1'b1;
					end else if (sts_read[g]) begin
						lock_changed_status[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ************************************************************
	// read mux: local port registers, main space, forwarded data
	// ************************************************************
	always @* begin
		next_rdata = `RST_BYTE;
		if (s_local) begin
			case (PORT_OFFSET)
			`OFS_STS_ONE: begin
				next_rdata[`STS_LOCK]     = PORT_LOCK[PORT_NUM];
				next_rdata[`STS_VALID]    = PORT_VALID[PORT_NUM];
				next_rdata[`STS_LOCK_CHG] =
					lock_changed_status[PORT_NUM];
			end
			`OFS_IRQ_EN: begin
				next_rdata[`IER_LOCK] = lock_change_irq_enable[PORT_NUM];
			end
			`OFS_IRQ_STS: begin
				next_rdata[`ISR_LOCK]  = lock_change_irq_flag[PORT_NUM];
				next_rdata[`ISR_VALID] = port_valid_change_flag[PORT_NUM];
			end
			default: begin
				next_rdata = `RST_BYTE;
			end
			endcase
		end else if (!s_main) begin
			next_rdata = PORT_RDATA;
		end else begin
			case (PORT_OFFSET)
			`OFS_IND_CTL: begin
				// only auto-increment and block bits are kept live
				next_rdata[`CTL_AUTO_INC] =
					indirect_block_control[`CTL_AUTO_INC];
				next_rdata[`CTL_BLK_HI:`CTL_BLK_LO] = IND_BLOCK;
			end
			`OFS_IND_ADDR: next_rdata = IND_ADDR;
			`OFS_IND_DATA: next_rdata = IND_RDATA;
			`OFS_PAGE_SEL: begin
				next_rdata[`PAGE_HI:`PAGE_LO] = page_sel;
			end
			// fixed at build time; writes to them fall through unused
			`OFS_IDENT_LO: next_rdata = IDENT_0;
			`OFS_IDENT_1: next_rdata = IDENT_1;
			`OFS_IDENT_2: next_rdata = IDENT_2;
			`OFS_IDENT_3: next_rdata = IDENT_3;
			`OFS_IDENT_4: next_rdata = IDENT_4;
			`OFS_IDENT_HI: next_rdata = IDENT_5;
			// bit 0 of an identifier byte is reserved and reads low
			`OFS_PORT_ID_LO: next_rdata = {port_id[0], 1'b0};
			`OFS_PORT_ID_1: next_rdata = {port_id[1], 1'b0};
			`OFS_PORT_ID_2: next_rdata = {port_id[2], 1'b0};
			`OFS_PORT_ID_HI: next_rdata = {port_id[3], 1'b0};
			default: next_rdata = `RST_BYTE;
			endcase
		end
	end

	// ************************************************************
	// answer stage
	// ************************************************************
	// read data holds until the next answer, so the host may fetch late
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ACC_RDATA  <= `RST_BYTE;
			ACC_RVALID <= 1'b0;
		end else begin
			ACC_RVALID <= s_rd;
			if (s_rd) begin
				ACC_RDATA <= next_rdata;
			end
		end
	end

endmodule // register_access_front_end

// File: design/reg_front_end_consts.vh
// Purpose: named offsets, fields and resets of the register front end
// Assumes: 8-bit offsets and 8-bit data, 7-bit bus identifiers
// Notes:   included by its bare name from the front end module
`ifndef REG_FRONT_END_CONSTS_VH
`define REG_FRONT_END_CONSTS_VH

// ****************************************************************
// main space offsets
// ****************************************************************
`define OFS_IND_CTL    8'hB0
`define OFS_IND_ADDR   8'hB1
`define OFS_IND_DATA   8'hB2
`define OFS_IDENT_LO   8'hF0
`define OFS_IDENT_HI   8'hF5
`define OFS_PORT_ID_LO 8'hF8
`define OFS_PORT_ID_HI 8'hFB
`define OFS_PAGE_SEL   8'h4C
`define OFS_IDENT_1    8'hF1
`define OFS_IDENT_2    8'hF2
`define OFS_IDENT_3    8'hF3
`define OFS_IDENT_4    8'hF4
`define OFS_PORT_ID_1  8'hF9
`define OFS_PORT_ID_2  8'hFA

// ****************************************************************
// per-port offsets (main space through page, or direct window)
// ****************************************************************
`define OFS_STS_ONE    8'h4D
`define OFS_IRQ_EN     8'hD8
`define OFS_IRQ_STS    8'hDB

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTL_AUTO_INC   1
`define CTL_BLK_HI     5
`define CTL_BLK_LO     2
`define STS_LOCK       0
`define STS_VALID      1
`define STS_LOCK_CHG   4
`define ISR_LOCK       0
`define ISR_VALID      1
`define IER_LOCK       0
`define ID_HI          7
`define ID_LO          1
`define PAGE_HI        1
`define PAGE_LO        0
`define ID_SEL_HI      1
`define ID_SEL_LO      0
`define RST_BYTE       8'h00
`define RST_ID         7'h00
`define RST_PAGE       2'h0
`define ONE_BYTE       8'h01
`define IDENT_BYTES    6

`endif

// File: tb/front_end_properties.sv
// Purpose: port checks for the register front end
// Assumes: the bench spaces control writes and data accesses
// Notes:   bound onto the front end below
`timescale 1ns/10ps
module front_end_checks #(
	parameter [6:0] MAIN_ID = 7'h30
) (
	input wire       REF_CLK,
	input wire       RST_N,
	input wire [6:0] ACC_ID,
	input wire [7:0] ACC_OFFSET,
	input wire [7:0] ACC_WDATA,
	input wire       ACC_WR,
	input wire       ACC_RD,
	input wire       ACC_HIT,
	input wire       ACC_RVALID,
	input wire       PORT_RD,
	input wire       PORT_WR,
	input wire [7:0] PORT_WDATA,
	input wire       IND_WR,
	input wire       IND_RD,
	input wire [3:0] IND_BLOCK,
	input wire [7:0] IND_ADDR
);
	reg       auto_on;
	reg [3:0] blk;
	wire      main_wr = ACC_WR && ACC_ID == MAIN_ID;
	wire      rd_req  = ACC_RD && !ACC_WR && ACC_HIT;
	// status, enable and flag registers are answered locally
	wire      fwd_ofs = ACC_OFFSET != 8'h4D && ACC_OFFSET != 8'hD8
		&& ACC_OFFSET != 8'hDB;
	wire      win_wr  = ACC_WR && ACC_HIT && ACC_ID != MAIN_ID;
	// control shadow, since only the bus side is visible here
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			auto_on <= 1'b0;
			blk     <= 4'h0;
		end else if (main_wr && ACC_OFFSET == 8'hB0) begin
			auto_on <= ACC_WDATA[1];
			blk     <= ACC_WDATA[5:2];
		end
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	sequence data_acc;
		IND_WR || IND_RD;
	endsequence
	read_answer_a: assert property (rd_req |-> ##2 ACC_RVALID)
		else $error("read not answered");
	no_stray_a: assert property (ACC_RVALID |-> $past(rd_req, 2))
		else $error("answer without read");
	ind_write_a: assert property (main_wr && ACC_OFFSET == 8'hB2
		|=> IND_WR && PORT_WDATA == $past(ACC_WDATA))
		else $error("data write not forwarded");
	ind_read_a: assert property (rd_req && ACC_ID == MAIN_ID
		&& ACC_OFFSET == 8'hB2 |=> IND_RD) else $error("no data read");
	auto_step_a: assert property (data_acc ##0 auto_on
		|=> IND_ADDR == $past(IND_ADDR) + 8'h01) else $error("no step");
	addr_hold_a: assert property (data_acc ##0 !auto_on
		|=> $stable(IND_ADDR)) else $error("offset moved");
	block_sel_a: assert property (data_acc |-> IND_BLOCK == blk)
		else $error("wrong block");
	zero_id_a: assert property (ACC_ID == 7'h00 && MAIN_ID != 7'h00
		|-> !ACC_HIT) else $error("zero id hit");
	window_fwd_a: assert property (rd_req && ACC_ID != MAIN_ID
		&& fwd_ofs |=> PORT_RD) else $error("window read lost");
	local_keep_a: assert property (rd_req && ACC_ID != MAIN_ID
		&& !fwd_ofs |=> !PORT_RD) else $error("local read forwarded");
	window_write_a: assert property (win_wr && fwd_ofs
		|=> PORT_WR && PORT_WDATA == $past(ACC_WDATA))
		else $error("window write lost");
endmodule // front_end_checks
bind register_access_front_end front_end_checks #(.MAIN_ID(MAIN_ID)) chk (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .ACC_ID(ACC_ID),
	.ACC_OFFSET(ACC_OFFSET), .ACC_WDATA(ACC_WDATA), .ACC_WR(ACC_WR),
	.ACC_RD(ACC_RD), .ACC_HIT(ACC_HIT), .ACC_RVALID(ACC_RVALID),
	.PORT_RD(PORT_RD), .PORT_WR(PORT_WR),
	.PORT_WDATA(PORT_WDATA), .IND_WR(IND_WR),
	.IND_RD(IND_RD), .IND_BLOCK(IND_BLOCK), .IND_ADDR(IND_ADDR));

// File: tb/front_end_far_side.sv
// Purpose: port banks and indirect blocks behind the front end
// Assumes: read data is sampled in the strobe cycle
// Notes:   idle outputs churn so stale samples never match
`timescale 1ns/10ps
module front_end_far_side (
	input  wire       REF_CLK,
	input  wire       PORT_RD,
	input  wire [1:0] PORT_NUM,
	input  wire [7:0] PORT_OFFSET,
	input  wire [7:0] PORT_WDATA,
	output wire [7:0] PORT_RDATA,
	input  wire       IND_WR,
	input  wire       IND_RD,
	input  wire [3:0] IND_BLOCK,
	input  wire [7:0] IND_ADDR,
	output wire [7:0] IND_RDATA
);
	reg [7:0] mem [0:4095];
	reg [7:0] churn = 8'h00;
	// one store per block and offset
	always @(posedge REF_CLK) begin
		churn <= churn + 8'h3B;
		if (IND_WR)
			mem[{IND_BLOCK, IND_ADDR}] <= PORT_WDATA;
	end
	assign PORT_RDATA = PORT_RD ? {PORT_NUM, PORT_OFFSET[5:0]} ^ 8'h5A : churn;
	assign IND_RDATA  = IND_RD ? mem[{IND_BLOCK, IND_ADDR}] : ~churn;
endmodule // front_end_far_side

// File: tb/test_register_access_front_end.sv
// Purpose: self-checking bench for the register front end
// Assumes: default main id 0x30 and default ident bytes
// Notes:   one request every three cycles keeps the pipe clear
`timescale 1ns/10ps
module test_register_access_front_end;
	reg        REF_CLK = 1'b0;
	reg        RST_N = 1'b0;
	reg  [6:0] ACC_ID = 7'h00;
	reg  [7:0] ACC_OFFSET = 8'h00;
	reg  [7:0] ACC_WDATA = 8'h00;
	reg        ACC_WR = 1'b0;
	reg        ACC_RD = 1'b0;
	reg  [3:0] PORT_LOCK = 4'h0;
	reg  [3:0] PORT_VALID = 4'h0;
	wire       ACC_HIT, ACC_RVALID, PORT_WR, PORT_RD, IND_WR, IND_RD;
	wire [1:0] PORT_NUM;
	wire [3:0] IND_BLOCK;
	wire [7:0] ACC_RDATA, PORT_OFFSET, PORT_WDATA, PORT_RDATA;
	wire [7:0] IND_ADDR, IND_RDATA;
	integer    n_errors = 0;
	integer    samples_checked = 0;
	integer    i, b, r;
	reg  [7:0] vals [0:2];
	reg  [6:0] pid;
	reg  [7:0] ofs;
	localparam [6:0] MID = 7'h30;
	register_access_front_end dut (.REF_CLK(REF_CLK), .RST_N(RST_N),
		.ACC_ID(ACC_ID), .ACC_OFFSET(ACC_OFFSET), .ACC_WDATA(ACC_WDATA),
		.ACC_WR(ACC_WR), .ACC_RD(ACC_RD), .ACC_HIT(ACC_HIT),
		.ACC_RDATA(ACC_RDATA), .ACC_RVALID(ACC_RVALID),
		.PORT_LOCK(PORT_LOCK), .PORT_VALID(PORT_VALID), .PORT_WR(PORT_WR),
		.PORT_RD(PORT_RD), .PORT_NUM(PORT_NUM), .PORT_OFFSET(PORT_OFFSET),
		.PORT_WDATA(PORT_WDATA), .PORT_RDATA(PORT_RDATA), .IND_WR(IND_WR),
		.IND_RD(IND_RD), .IND_BLOCK(IND_BLOCK), .IND_ADDR(IND_ADDR),
		.IND_RDATA(IND_RDATA));
	front_end_far_side far (.REF_CLK(REF_CLK), .PORT_RD(PORT_RD),
		.PORT_NUM(PORT_NUM), .PORT_OFFSET(PORT_OFFSET),
		.PORT_WDATA(PORT_WDATA), .PORT_RDATA(PORT_RDATA), .IND_WR(IND_WR),
		.IND_RD(IND_RD), .IND_BLOCK(IND_BLOCK), .IND_ADDR(IND_ADDR),
		.IND_RDATA(IND_RDATA));
	// ****************************************************************
	// tasks
	// ****************************************************************
	initial forever #25 REF_CLK = ~REF_CLK;
	task chk(input [7:0] got, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// far side answers forwarded reads with port and low offset bits
	function [7:0] win_exp(input [1:0] p, input [7:0] o);
		begin
			win_exp = {p, o[5:0]} ^ 8'h5A;
		end
	endfunction
	// one-cycle strobe; answer lands one edge after it is taken
	task acc(input [6:0] id, input [7:0] ofs, input [7:0] d, input wr);
		begin
			@(negedge REF_CLK);
			ACC_ID = id;
			ACC_OFFSET = ofs;
			ACC_WDATA = d;
			ACC_WR = wr;
			ACC_RD = !wr;
			@(negedge REF_CLK);
			ACC_WR = 1'b0;
			ACC_RD = 1'b0;
			@(negedge REF_CLK);
		end
	endtask
	task rd(input [6:0] id, input [7:0] ofs, input [7:0] exp);
		begin
			acc(id, ofs, 8'h00, 1'b0);
			chk(ACC_RDATA, exp);
		end
	endtask
	task end_sim;
		begin
			$display("checked %0d errors %0d", samples_checked, n_errors);
			if (n_errors == 0 && samples_checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		r = $urandom(32'h0A2F);
		repeat (10) @(negedge REF_CLK);
		RST_N = 1'b1;
		acc(7'h00, 8'hF0, 8'hFF, 1'b1);
		acc(MID, 8'hF0, 8'h00, 1'b1);
		for (i = 0; i < 6; i = i + 1)
			rd(MID, 8'hF0 + i[7:0], 8'h61 + i[7:0]);
		// open each window, then read a random forwarded offset
		for (i = 0; i < 4; i = i + 1) begin
			pid = 7'h40 + i[6:0];
			rd(MID, 8'hF8 + i[7:0], 8'h00);
			acc(MID, 8'hF8 + i[7:0], {pid, 1'b1}, 1'b1);
			rd(MID, 8'hF8 + i[7:0], {pid, 1'b0});
			r = $urandom;
			ofs = {2'b00, r[5:0]};
			acc(pid, {2'b00, r[13:8]}, r[23:16], 1'b1);
			rd(pid, ofs, win_exp(i[1:0], ofs));
		end
		// block codes 0 to 7, with auto-increment on
		for (b = 0; b < 8; b = b + 1) begin
			acc(MID, 8'hB0, {2'b00, b[3:0], 2'b10}, 1'b1);
			acc(MID, 8'hB1, 8'h10, 1'b1);
			for (i = 0; i < 3; i = i + 1) begin
				r = $urandom;
				vals[i] = r[7:0];
				acc(MID, 8'hB2, vals[i], 1'b1);
			end
			acc(MID, 8'hB1, 8'h10, 1'b1);
			for (i = 0; i < 3; i = i + 1)
				rd(MID, 8'hB2, vals[i]);
		end
		acc(MID, 8'hB0, 8'h00, 1'b1);
		acc(MID, 8'hB2, 8'hC3, 1'b1);
		acc(MID, 8'hB2, 8'h3C, 1'b1);
		rd(MID, 8'hB2, 8'h3C);
		rd(MID, 8'hB2, 8'h3C);
		// lock irq enabled on port 0 only; valid moves on port 1
		acc(7'h40, 8'hD8, 8'h01, 1'b1);
		PORT_LOCK = 4'h3;
		PORT_VALID = 4'h2;
		rd(7'h40, 8'hDB, 8'h01);
		rd(7'h41, 8'hDB, 8'h02);
		rd(7'h40, 8'h4D, 8'h11);
		rd(7'h41, 8'h4D, 8'h13);
		rd(7'h40, 8'hDB, 8'h00);
		rd(7'h41, 8'hDB, 8'h00);
		// main space reaches port 1 through the page register
		acc(MID, 8'h4C, 8'h01, 1'b1);
		rd(MID, 8'h4C, 8'h01);
		rd(MID, 8'h4D, 8'h03);
		rd(MID, 8'hDB, 8'h00);
		end_sim;
	end
	// the tests need well under 50 us
	initial begin
		#2000000;
		n_errors = n_errors + 1;
		end_sim;
	end
endmodule // test_register_access_front_end
